// file: qwis_map.svh
// Operation
// - set tx-stopped flag bit 9, hold it
// - set rx-stopped flag bit 8, hold it
// - stopped flags clear only on write one
// - set tx-space flag bit 6 on event
// - wake frame bit 5, cleared by code 1000
// - remote wake bit 4, cleared by code 0100
// - linkup wake bit 3, cleared by code 0010
// - energy bit 2 gated by enable, code 0001
// - interrupt when any flag and enable set
// - reading status never clears any flag
`ifndef QWIS_MAP_SVH
`define QWIS_MAP_SVH

`define QWIS_ADDR_W        12
`define QWIS_DATA_W        16
`define QWIS_ENABLE_OFS    12'h190
`define QWIS_STATUS_OFS    12'h192
`define QWIS_PMC_OFS       12'h084
`define QWIS_RST_VAL       16'h0000
`define QWIS_ENABLE_WMASK  16'hFFFC
`define QWIS_TXPS_BIT      9
`define QWIS_RXPS_BIT      8
`define QWIS_TXSA_BIT      6
`define QWIS_WF_BIT        5
`define QWIS_RWP_BIT       4
`define QWIS_LU_BIT        3
`define QWIS_ED_BIT        2
`define QWIS_WAKE_MSB      5
`define QWIS_WAKE_LSB      2
`define QWIS_CLR_WF        4'h8
`define QWIS_CLR_RWP       4'h4
`define QWIS_CLR_LU        4'h2
`define QWIS_CLR_ED        4'h1
`define QWIS_ACK_LAT       1

`endif

// file: qwis_pkg.sv
`include "qwis_map.svh"
package qwis_pkg;
    typedef logic [`QWIS_ADDR_W-1:0] qwis_addr_t;
    typedef logic [`QWIS_DATA_W-1:0] qwis_data_t;

    // device end state
    typedef struct packed {
        qwis_data_t interrupt_enable;
        qwis_data_t pmc;
        qwis_data_t interrupt_status;
        logic [6:0] evt_prev;
        qwis_data_t rdata;
        logic       ack;
        logic       irq_n;
    } qwis_dev_s;

    typedef enum logic [1:0] {
        QWIS_IDLE = 2'b01,
        QWIS_BUSY = 2'b10
    } qwis_host_e;

    // host end state
    typedef struct packed {
        qwis_host_e st;
        qwis_addr_t addr;
        qwis_data_t wdata;
        logic [1:0] be;
        logic       wr;
        logic       rd;
        logic       ready;
        logic       rsp_valid;
        qwis_data_t rsp_data;
        logic       irq;
    } qwis_host_s;
endpackage

// file: qwis_if.sv
`timescale 1ns/1ps
interface qwis_if;
    import qwis_pkg::*;
    qwis_addr_t reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [1:0] reg_be;
    qwis_data_t reg_wdata;
    qwis_data_t reg_rdata;
    logic       reg_ack;
    logic       irq_n;

    modport dev (
        input  reg_addr,
        input  reg_wr,
        input  reg_rd,
        input  reg_be,
        input  reg_wdata,
        output reg_rdata,
        output reg_ack,
        output irq_n
    );
    modport host (
        output reg_addr,
        output reg_wr,
        output reg_rd,
        output reg_be,
        output reg_wdata,
        input  reg_rdata,
        input  reg_ack,
        input  irq_n
    );
endinterface

// file: qwis_dev.sv
`timescale 1ns/1ps
`include "qwis_map.svh"
module qwis_dev #(
    parameter int ADDR_W = `QWIS_ADDR_W
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    qwis_if.dev       bus,
    input  wire logic tx_stop,
    input  wire logic rx_stop,
    input  wire logic tx_space,
    input  wire logic wake_frame,
    input  wire logic remote_wake,
    input  wire logic linkup_wake,
    input  wire logic energy_wake
);
    import qwis_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // elaboration check

    // decode needs the full offset width of the status register
    if (ADDR_W != `QWIS_ADDR_W) begin : g_bad_addr
        $error("qwis_dev: ADDR_W must match the bus address width");
    end

    // every flag position must sit inside the status word
    if (`QWIS_TXPS_BIT >= `QWIS_DATA_W || `QWIS_RXPS_BIT >= `QWIS_DATA_W ||
        `QWIS_TXSA_BIT >= `QWIS_DATA_W || `QWIS_WF_BIT >= `QWIS_DATA_W ||
        `QWIS_RWP_BIT >= `QWIS_DATA_W || `QWIS_LU_BIT >= `QWIS_DATA_W ||
        `QWIS_ED_BIT >= `QWIS_DATA_W) begin : g_bad_flag_pos
        $error("qwis_dev: flag position outside the status word");
    end

    // the wake decode compares a four-bit field with four-bit codes
    if (`QWIS_WAKE_MSB - `QWIS_WAKE_LSB != 3) begin : g_bad_wake_field
        $error("qwis_dev: wake field must be four bits wide");
    end

    // two flags sharing one clear code: the case takes the first match, so the later flag would never clear
    if (`QWIS_CLR_WF == `QWIS_CLR_RWP || `QWIS_CLR_WF == `QWIS_CLR_LU ||
        `QWIS_CLR_WF == `QWIS_CLR_ED || `QWIS_CLR_RWP == `QWIS_CLR_LU ||
        `QWIS_CLR_RWP == `QWIS_CLR_ED || `QWIS_CLR_LU == `QWIS_CLR_ED) begin : g_bad_wake_codes
        $error("qwis_dev: wake clear codes must all differ");
    end

    ////////////////////////////////////////////////////////////////////
    // state

    qwis_dev_s s;
    qwis_dev_s next_s;

    logic [6:0] evt_now;
    logic [6:0] evt_rise;
    qwis_data_t lane_mask;
    qwis_data_t wr_data;
    logic       hit_enable;
    logic       hit_status;
    logic       hit_pmc;
    logic       wr_status;
    logic       wr_pmc;
    logic [3:0] wake_code;
    qwis_data_t set_vec;
    qwis_data_t clr_vec;

    ////////////////////////////////////////////////////////////////////
    // implemented status bits

    // reserved positions are forced to zero whatever the terms say,
    // so a later edit of a set or clear term cannot expose them
    localparam qwis_data_t STATUS_IMPL_MASK = (16'h0001 << `QWIS_TXPS_BIT) | (16'h0001 << `QWIS_RXPS_BIT) |
                                              (16'h0001 << `QWIS_TXSA_BIT) | (16'h0001 << `QWIS_WF_BIT) |
                                              (16'h0001 << `QWIS_RWP_BIT) | (16'h0001 << `QWIS_LU_BIT) |
                                              (16'h0001 << `QWIS_ED_BIT);

    ////////////////////////////////////////////////////////////////////
    // event sampling

    // events come from logic on mclk, so no synchroniser
    assign evt_now = {tx_stop, rx_stop, tx_space, wake_frame,
                      remote_wake, linkup_wake, energy_wake};

    // edge-triggered: a held level sets its flag only once, so a level
    // still high after the host clears the flag does not set it again
    assign evt_rise = evt_now & ~s.evt_prev;

    ////////////////////////////////////////////////////////////////////
    // address decode and byte lanes

    assign hit_enable = (bus.reg_addr == `QWIS_ENABLE_OFS);
    assign hit_status = (bus.reg_addr == `QWIS_STATUS_OFS);
    assign hit_pmc    = (bus.reg_addr == `QWIS_PMC_OFS);

    // 8-bit hosts write one lane at a time
    assign lane_mask = {{8{bus.reg_be[1]}}, {8{bus.reg_be[0]}}};
    assign wr_data   = bus.reg_wdata & lane_mask;

    assign wr_status = bus.reg_wr & hit_status;
    assign wr_pmc    = bus.reg_wr & hit_pmc & bus.reg_be[0];

    // wake field lives in the low byte only, so a write of the high
    // byte alone never carries a wake command
    assign wake_code = bus.reg_wdata[`QWIS_WAKE_MSB:`QWIS_WAKE_LSB];

    ////////////////////////////////////////////////////////////////////
    // flag set terms

    always_comb begin
        set_vec = `QWIS_RST_VAL;
        set_vec[`QWIS_TXPS_BIT] = evt_rise[6];
        set_vec[`QWIS_RXPS_BIT] = evt_rise[5];
        set_vec[`QWIS_TXSA_BIT] = evt_rise[4];
        set_vec[`QWIS_WF_BIT]   = evt_rise[3];
        set_vec[`QWIS_RWP_BIT]  = evt_rise[2];
        set_vec[`QWIS_LU_BIT]   = evt_rise[1];
        // energy wake is reported only while its enable is on
        set_vec[`QWIS_ED_BIT]   = evt_rise[0] & s.interrupt_enable[`QWIS_ED_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // flag clear terms

    // only the listed bits ever get a clear term; reserved and
    // wake bits are untouched by a status write
    always_comb begin
        clr_vec = `QWIS_RST_VAL;
        if (wr_status) begin
            // write one clears, zero leaves the flag alone
            clr_vec[`QWIS_TXPS_BIT] = wr_data[`QWIS_TXPS_BIT];
            clr_vec[`QWIS_RXPS_BIT] = wr_data[`QWIS_RXPS_BIT];
            clr_vec[`QWIS_TXSA_BIT] = wr_data[`QWIS_TXSA_BIT];
        end
        if (wr_pmc) begin
            // one exact code per wake flag; other codes clear nothing
            case (wake_code)
                `QWIS_CLR_WF:  clr_vec[`QWIS_WF_BIT]  = 1'b1;
                `QWIS_CLR_RWP: clr_vec[`QWIS_RWP_BIT] = 1'b1;
                `QWIS_CLR_LU:  clr_vec[`QWIS_LU_BIT]  = 1'b1;
                `QWIS_CLR_ED:  clr_vec[`QWIS_ED_BIT]  = 1'b1;
                default:       ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s          = s;
        next_s.evt_prev = evt_now;
        next_s.ack      = bus.reg_wr | bus.reg_rd;

        // set wins over a clear landing in the same cycle
        next_s.interrupt_status = ((s.interrupt_status & ~clr_vec) | set_vec) & STATUS_IMPL_MASK;

        // enable register, low two bits stay zero
        if (bus.reg_wr && hit_enable) begin
            next_s.interrupt_enable = ((s.interrupt_enable & ~lane_mask) | wr_data) & `QWIS_ENABLE_WMASK;
        end

        // control register keeps its bits, but the wake field is a
        // command and reads back as zero
        if (bus.reg_wr && hit_pmc) begin
            next_s.pmc = (s.pmc & ~lane_mask) | wr_data;
            next_s.pmc[`QWIS_WAKE_MSB:`QWIS_WAKE_LSB] = 4'h0;
        end

        // read data; unmapped offsets answer zero
        // a read has no side effect on any flag
        next_s.rdata = `QWIS_RST_VAL;
        if (bus.reg_rd) begin
            if (hit_enable) begin
                next_s.rdata = s.interrupt_enable;
            end else if (hit_status) begin
                next_s.rdata = s.interrupt_status;
            end else if (hit_pmc) begin
                next_s.rdata = s.pmc;
            end else begin
                next_s.rdata = `QWIS_RST_VAL;
            end
        end

        // pin is registered from the next flags, so it changes on the same edge as they do
        next_s.irq_n = ~|(next_s.interrupt_status & next_s.interrupt_enable);
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    // everything clears to zero, reserved bits included, except irq_n, which resets high
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s          <= '0;
            s.irq_n    <= 1'b1;
        end else if (clk_en) begin
            // a frozen cycle also freezes the edge memory, so an event
            // that comes and goes while frozen is never seen
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state flops

    assign bus.reg_rdata = s.rdata;
    assign bus.reg_ack   = s.ack;
    assign bus.irq_n     = s.irq_n;

endmodule

// file: qwis_host.sv
`timescale 1ns/1ps
`include "qwis_map.svh"
module qwis_host (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    qwis_if.host              bus,
    input  wire logic         cmd_valid,
    input  wire logic         cmd_write,
    input  qwis_pkg::qwis_addr_t cmd_addr,
    input  qwis_pkg::qwis_data_t cmd_wdata,
    input  wire logic [1:0]   cmd_be,
    output logic              cmd_ready,
    output logic              rsp_valid,
    output qwis_pkg::qwis_data_t rsp_data,
    output logic              irq
);
    import qwis_pkg::*;

    qwis_host_s s;
    qwis_host_s next_s;

    ////////////////////////////////////////////////////////////////////
    // one access at a time; the device always answers, so no timeout
    always_comb begin
        next_s           = s;
        next_s.wr        = 1'b0;
        next_s.rd        = 1'b0;
        next_s.rsp_valid = 1'b0;
        next_s.irq       = ~bus.irq_n;
        case (s.st)
            QWIS_IDLE: begin
                if (cmd_valid) begin
                    next_s.st    = QWIS_BUSY;
                    next_s.addr  = cmd_addr;
                    next_s.wdata = cmd_wdata;
                    next_s.be    = cmd_be;
                    next_s.wr    = cmd_write;
                    next_s.rd    = ~cmd_write;
                    next_s.ready = 1'b0;
                end
            end
            QWIS_BUSY: begin
                if (bus.reg_ack) begin
                    next_s.st        = QWIS_IDLE;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data  = bus.reg_rdata;
                    next_s.ready     = 1'b1;
                end
            end
            default: begin
                next_s.st    = QWIS_IDLE;
                next_s.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s       <= '0;
            s.st    <= QWIS_IDLE;
            s.ready <= 1'b1;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign bus.reg_addr  = s.addr;
    assign bus.reg_wr    = s.wr;
    assign bus.reg_rd    = s.rd;
    assign bus.reg_be    = s.be;
    assign bus.reg_wdata = s.wdata;
    assign cmd_ready     = s.ready;
    assign rsp_valid     = s.rsp_valid;
    assign rsp_data      = s.rsp_data;
    assign irq           = s.irq;

endmodule

// file: qwis_properties.sv
`timescale 1ns/1ps
module qwis_properties (
    input wire logic            mclk,
    input wire logic            sys_rst,
    input qwis_pkg::qwis_addr_t reg_addr,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [1:0]      reg_be,
    input qwis_pkg::qwis_data_t reg_wdata,
    input qwis_pkg::qwis_data_t reg_rdata,
    input wire logic            reg_ack,
    input wire logic            irq_n
);
    import qwis_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // bus timing: one answer, one cycle after each strobe
    a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("strobe not acked");
    a_ack_caused: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("ack without strobe");
    // host end spaces strobes so the answer never overlaps a request
    a_strobe_gap: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd) [*2])
        else $error("strobes too close");
    a_one_strobe: assert property (!(reg_wr && reg_rd))
        else $error("read and write together");
    a_rdata_idle: assert property (!reg_ack |-> reg_rdata == 16'h0000)
        else $error("read data outside ack");
    ////////////////////////////////////////////////////////////////
    // read values and out-of-reset outputs that never depend on events
    a_isr_reserved: assert property (reg_ack && $past(reg_rd && reg_addr == 12'h192) |->
        (reg_rdata & 16'hFC83) == 16'h0000) else $error("reserved status bit set");
    a_ier_low_bits: assert property (reg_ack && $past(reg_rd && reg_addr == 12'h190) |->
        reg_rdata[1:0] == 2'h0) else $error("enable low bits set");
    a_unmapped_zero: assert property (reg_ack && $past(reg_rd && !(reg_addr inside {12'h190, 12'h192, 12'h084}))
        |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_reset_idle: assert property ($fell(sys_rst) |-> irq_n && !reg_ack)
        else $error("pin active out of reset");
    ////////////////////////////////////////////////////////////////
    // enable register mirror, rebuilt from the writes seen on the bus
    qwis_data_t enable_shadow;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            enable_shadow <= 16'h0000;
        end else if (reg_wr && reg_addr == 12'h190) begin
            enable_shadow <= ((enable_shadow & ~{{8{reg_be[1]}}, {8{reg_be[0]}}}) |
                              (reg_wdata & {{8{reg_be[1]}}, {8{reg_be[0]}}})) & 16'hFFFC;
        end
    end
    a_enable_readback: assert property (reg_ack && $past(reg_rd && reg_addr == 12'h190) |->
        reg_rdata == enable_shadow) else $error("enable read back wrong");
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import qwis_pkg::*;
    logic       mclk       = 1'b0;
    logic       sys_rst    = 1'b1;
    logic       clk_en     = 1'b1;
    logic [6:0] evt        = 7'h00; // tx rx space frame remote link energy
    logic       cmd_valid  = 1'b0;
    logic       cmd_write  = 1'b0;
    qwis_addr_t cmd_addr   = 12'h000;
    qwis_data_t cmd_wdata  = 16'h0000;
    logic       cmd_ready;
    logic       rsp_valid;
    logic       irq;
    qwis_data_t rsp_data;
    qwis_data_t rd;
    int         err_count  = 0;
    int         num_checks = 0;
    int         cycles     = 0;
    ////////////////////////////////////////////////////////////////
    always #5 mclk = ~mclk;
    qwis_if bif ();
    qwis_dev qwis_dev_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bif),
        .tx_stop(evt[6]), .rx_stop(evt[5]), .tx_space(evt[4]), .wake_frame(evt[3]),
        .remote_wake(evt[2]), .linkup_wake(evt[1]), .energy_wake(evt[0]));
    qwis_host qwis_host_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bif),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_be(2'h3), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq(irq));
    qwis_properties qwis_properties_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(bif.reg_addr),
        .reg_wr(bif.reg_wr), .reg_rd(bif.reg_rd), .reg_be(bif.reg_be), .reg_wdata(bif.reg_wdata),
        .reg_rdata(bif.reg_rdata), .reg_ack(bif.reg_ack), .irq_n(bif.irq_n));
    ////////////////////////////////////////////////////////////////
    task automatic check(input qwis_data_t got, input qwis_data_t exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one command through the host end; bounded wait for its response
    task automatic bus(input int w, input qwis_addr_t a, input qwis_data_t d);
        int n;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= (w != 0);
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 8 && rsp_valid !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (n == 8) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rsp_valid, 1'b1);
        end
        rd = rsp_data;
        // host end is ready again in the cycle of its response
        check({15'h0, cmd_ready}, 16'h0001);
    endtask
    // rising edge on the chosen event inputs, then time to latch
    task automatic pulse(input logic [6:0] m);
        @(posedge mclk);
        evt <= m;
        @(posedge mclk);
        evt <= 7'h00;
        repeat (2) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0000);
        bus(0, 12'h190, 16'h0000);
        check(rd, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_stopped;
        bus(1, 12'h190, 16'h0300);
        pulse(7'h40);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0200);
        check({15'h0, bif.irq_n}, 16'h0000);
        check({15'h0, irq}, 16'h0001);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0200);
        bus(1, 12'h192, 16'h0000);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0200);
        pulse(7'h20);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0300);
        bus(1, 12'h192, 16'h0200);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0100);
        bus(1, 12'h192, 16'h0100);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0000);
        check({15'h0, bif.irq_n}, 16'h0001);
        $display("test stopped done");
    endtask
    // space flag with its enable off: latched but pin stays quiet
    task automatic t_space;
        pulse(7'h10);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0040);
        check({15'h0, bif.irq_n}, 16'h0001);
        bus(1, 12'h192, 16'h0040);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0000);
        $display("test space done");
    endtask
    task automatic t_wake;
        qwis_data_t exp;
        bus(1, 12'h190, 16'h0000);
        pulse(7'h01);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0000);
        bus(1, 12'h190, 16'h003C);
        pulse(7'h0F);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h003C);
        check({15'h0, bif.irq_n}, 16'h0000);
        bus(1, 12'h192, 16'hFFFF);
        bus(1, 12'h084, 16'h000C);
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h003C);
        exp = 16'h003C;
        // codes 8,4,2,1 in the wake field each clear one flag
        for (int i = 0; i < 4; i++) begin
            bus(1, 12'h084, 16'h0020 >> i);
            exp = exp & ~(16'h0020 >> i);
            bus(0, 12'h192, 16'h0000);
            check(rd, exp);
        end
        bus(0, 12'h194, 16'h0000);
        check(rd, 16'h0000);
        $display("test wake done");
    endtask
    // clock enable low: a pulse that comes and goes while frozen is never seen
    task automatic t_freeze;
        @(posedge mclk);
        clk_en <= 1'b0;
        pulse(7'h40);
        @(posedge mclk);
        clk_en <= 1'b1;
        bus(0, 12'h192, 16'h0000);
        check(rd, 16'h0000);
        $display("test freeze done");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the roughly 170 cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out;
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset;
        t_stopped;
        t_space;
        t_wake;
        t_freeze;
        close_out;
    end
endmodule
